// *** gpq_pads.sv ***
// Pad model: device drive, outside drive, pull-ups, floating pads
`timescale 1ns/100ps
module gpq_pads (
  input  wire logic        clock,
  input  wire logic [34:0] pin_out,
  input  wire logic [34:0] pin_oe,
  input  wire logic [34:0] pullup_en,
  input  wire logic [34:0] ext_val,
  input  wire logic [34:0] ext_oe,
  output logic      [34:0] pin_in
);
  logic flt_reg = 1'b0;
  // Undriven pad without pull-up wanders, so nobody may rely on it
  always @(posedge clock) flt_reg <= ~flt_reg;
  always_comb begin
    for (int i = 0; i < 35; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : flt_reg;
    end
  end
endmodule

// *** gpq_pkg.sv ***
// Package with register map, field layout and reset values for the pin port
package gpq_pkg;
  localparam int GPQ_NUM_PINS = 35;
  localparam int GPQ_PORT_B_PINS = 3;
  localparam int GPQ_PWM_PINS = 12;
  localparam int GPQ_ADDR_W = 16;
  // Printed word offsets, also used as indices; byte address is twice these
  localparam logic [15:0] GPQ_PORT_A_PIN_LEVEL     = 16'h6FC0;
  localparam logic [15:0] GPQ_PORT_A_LATCH_RAISE   = 16'h6FC2;
  localparam logic [15:0] GPQ_PORT_A_LATCH_LOWER   = 16'h6FC4;
  localparam logic [15:0] GPQ_PORT_A_LATCH_INVERT  = 16'h6FC6;
  localparam logic [15:0] GPQ_PORT_B_PIN_LEVEL     = 16'h6FC8;
  localparam logic [15:0] GPQ_PORT_B_LATCH_RAISE   = 16'h6FCA;
  localparam logic [15:0] GPQ_PORT_B_LATCH_LOWER   = 16'h6FCC;
  localparam logic [15:0] GPQ_PORT_B_LATCH_INVERT  = 16'h6FCE;
  localparam logic [15:0] GPQ_PORT_A_SAMPLE_PERIOD = 16'h6F80;
  localparam logic [15:0] GPQ_PORT_A_LOW_QUAL      = 16'h6F82;
  localparam logic [15:0] GPQ_PORT_A_HIGH_QUAL     = 16'h6F84;
  localparam logic [15:0] GPQ_PORT_A_LOW_FUNC      = 16'h6F86;
  localparam logic [15:0] GPQ_PORT_A_HIGH_FUNC     = 16'h6F88;
  localparam logic [15:0] GPQ_PORT_A_DIRECTION     = 16'h6F8A;
  localparam logic [15:0] GPQ_PORT_A_PULLUP_OFF    = 16'h6F8C;
  localparam logic [15:0] GPQ_PORT_B_SAMPLE_PERIOD = 16'h6F90;
  localparam logic [15:0] GPQ_PORT_B_QUAL          = 16'h6F92;
  localparam logic [15:0] GPQ_PORT_B_FUNC          = 16'h6F96;
  localparam logic [15:0] GPQ_PORT_B_DIRECTION     = 16'h6F9A;
  localparam logic [15:0] GPQ_PORT_B_PULLUP_OFF    = 16'h6F9C;
  localparam logic [15:0] GPQ_EXT_IRQ_ONE_SOURCE   = 16'h6FE0;
  localparam logic [15:0] GPQ_EXT_IRQ_TWO_SOURCE   = 16'h6FE1;
  localparam logic [15:0] GPQ_EXT_NMI_SOURCE       = 16'h6FE2;
  localparam logic [15:0] GPQ_WAKE_SOURCE_SELECT   = 16'h6FE8;
  // Reset values
  localparam logic [34:0] GPQ_PULLUP_OFF_RESET = 35'h0_0000_0FFF;
  localparam logic [69:0] GPQ_QUAL_RESET       = 70'h0;
  localparam logic [69:0] GPQ_FUNC_RESET       = 70'h0;
  localparam logic [34:0] GPQ_DIR_RESET        = 35'h0;
  localparam logic [34:0] GPQ_LATCH_RESET      = 35'h0;
  localparam logic [4:0]  GPQ_SRC_RESET        = 5'h00;
  // Qualifier codes, two bits per pin
  localparam logic [1:0] GPQ_QUAL_SYNC  = 2'h0;
  localparam logic [1:0] GPQ_QUAL_THREE = 2'h1;
  localparam logic [1:0] GPQ_QUAL_SIX   = 2'h2;
  localparam logic [1:0] GPQ_QUAL_ASYNC = 2'h3;
  localparam logic [1:0] GPQ_FUNC_GPIO  = 2'h0;
  localparam int GPQ_SAMPLES_THREE = 3;
  localparam int GPQ_SAMPLES_SIX   = 6;
  localparam int GPQ_GROUP_PINS    = 8;
  localparam int GPQ_PERIOD_W      = 8;
  localparam int GPQ_NUM_GROUPS    = 5;
endpackage

// *** gpq_port.sv ***
// Contract
// - 35 pins, GPIO or three peripheral functions
// - Pullups off on twelve PWM pins
// - Other pullups on until disabled
// - Inputs reset to synchronize-only qualification
// - All pins reset as GPIO inputs
// - Output latches reset to zero
// - Per-pin wake source selection for sleep; the code has a 32-bit select, Port A pins only
// - Port A pin selectable per external interrupt
// - Data read returns qualified pin level
// - Data write loads latch; drive if output
// - Latch kept and driven once output
// - Raise reads zero, ones set latches
// - Lower reads zero, ones clear latches
// - Invert reads zero, ones flip latches
// - Sync-only or window; peripherals also async
// - Async path bypasses synchroniser entirely
// - GPIO input with async uses sync-only
// - Sync-only adds one synchroniser, no filter
// - Window passes change after 3/6 samples
// - Period one cycle if zero, else 2n
// - One period field per eight pins
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module gpq_port
  import gpq_pkg::*;
#(
  parameter int NUM_PINS = GPQ_NUM_PINS
)
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [GPQ_ADDR_W-1:0] addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [31:0]           rdata,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  output logic      [NUM_PINS-1:0]   pin_out,
  output logic      [NUM_PINS-1:0]   pin_oe,
  output logic      [NUM_PINS-1:0]   pullup_en,
  output logic      [NUM_PINS-1:0]   periph_in,
  input  wire logic [NUM_PINS-1:0]   periph_out,
  input  wire logic [NUM_PINS-1:0]   periph_oe,
  output logic      [69:0]           function_sel,
  output logic      [31:0]           wake_source_select,
  output logic                       ext_irq_one,
  output logic                       ext_irq_two,
  output logic                       ext_nonmaskable_irq
);
  logic [NUM_PINS-1:0] latch_reg;
  logic [NUM_PINS-1:0] latch_next;
  logic [NUM_PINS-1:0] dir_reg;
  logic [NUM_PINS-1:0] pull_off_reg;
  logic [69:0]         qual_reg;
  logic [69:0]         func_reg;
  logic [31:0]         ctl_a_reg;
  logic [31:0]         ctl_b_reg;
  logic [31:0]         wake_reg;
  logic [4:0]          src_one_reg;
  logic [4:0]          src_two_reg;
  logic [4:0]          src_nmi_reg;
  logic [31:0]         rdata_reg;
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] is_gpio;
  logic [NUM_PINS-1:0] wr_mask;
  logic [NUM_PINS-1:0] raise_m;
  logic [NUM_PINS-1:0] lower_m;
  logic [NUM_PINS-1:0] invert_m;
  logic [NUM_PINS-1:0] load_m;
  logic [NUM_PINS-1:0] wr_val;
  logic [GPQ_NUM_GROUPS-1:0] tick;
  logic [GPQ_PERIOD_W-1:0]   period [GPQ_NUM_GROUPS];
  logic [GPQ_PERIOD_W:0]     cnt_reg [GPQ_NUM_GROUPS];
  logic [31:0]         rd_mux;
  logic                wr_a;
  logic                wr_b;

  function automatic logic hit(input logic [GPQ_ADDR_W-1:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  // Widen a port-relative write word into the 35-bit pin vector
  function automatic logic [NUM_PINS-1:0] spread(input logic [31:0] d, input logic port_b);
    logic [63:0] v;
    v = port_b ? {29'h0, d[GPQ_PORT_B_PINS-1:0], 32'h0} : {32'h0, d};
    spread = v[NUM_PINS-1:0];
  endfunction

  // Each group of eight pins shares one period field
  genvar g;
  generate
    for (g = 0; g < GPQ_NUM_GROUPS; g++) begin : grp
      if (g < 4) begin : ga
        assign period[g] = ctl_a_reg[g*8 +: 8];
      end else begin : gb
        assign period[g] = ctl_b_reg[7:0];
      end
      // Zero field ticks every cycle, otherwise every 2n cycles
      always_ff @(posedge clock) begin
        if (!reset_n)
          cnt_reg[g] <= '0;
        else if (tick[g])
          cnt_reg[g] <= '0;
        else
          cnt_reg[g] <= cnt_reg[g] + 9'h001;
      end
      assign tick[g] = (period[g] == 8'h00) ||
                       (cnt_reg[g] >= ({period[g], 1'b0} - 9'h001));
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : pin
      assign is_gpio[p] = (func_reg[2*p +: 2] == GPQ_FUNC_GPIO);
      gpq_qualifier u_qual (
        .clock       (clock),
        .reset_n     (reset_n),
        .pin_in      (pin_in[p]),
        .sample_tick (tick[p/GPQ_GROUP_PINS]),
        .qual_sel    (qual_reg[2*p +: 2]),
        .is_gpio     (is_gpio[p]),
        .level       (level[p])
      );
      // Latch reaches the pin only as a GPIO output; otherwise peripheral drives
      assign pin_out[p] = is_gpio[p] ? latch_reg[p] : periph_out[p];
      assign pin_oe[p]  = is_gpio[p] ? dir_reg[p] : periph_oe[p];
    end
  endgenerate

  assign periph_in = level;
  assign pullup_en = ~pull_off_reg;
  assign function_sel = func_reg;
  assign wake_source_select = wake_reg;
  assign ext_irq_one = level[src_one_reg];
  assign ext_irq_two = level[src_two_reg];
  assign ext_nonmaskable_irq = level[src_nmi_reg];

  // Write decode; raise/lower/invert never store, they only act on the latch
  assign wr_a     = wr_en && hit(addr, GPQ_PORT_A_PIN_LEVEL);
  assign wr_b     = wr_en && hit(addr, GPQ_PORT_B_PIN_LEVEL);
  assign load_m   = (wr_a ? spread(32'hFFFF_FFFF, 1'b0) : '0) |
                    (wr_b ? spread(32'hFFFF_FFFF, 1'b1) : '0);
  assign wr_val   = spread(wdata, wr_b);
  assign wr_mask  = load_m;
  assign raise_m  = (wr_en && hit(addr, GPQ_PORT_A_LATCH_RAISE)) ? spread(wdata, 1'b0) :
                    (wr_en && hit(addr, GPQ_PORT_B_LATCH_RAISE)) ? spread(wdata, 1'b1) : '0;
  assign lower_m  = (wr_en && hit(addr, GPQ_PORT_A_LATCH_LOWER)) ? spread(wdata, 1'b0) :
                    (wr_en && hit(addr, GPQ_PORT_B_LATCH_LOWER)) ? spread(wdata, 1'b1) : '0;
  assign invert_m = (wr_en && hit(addr, GPQ_PORT_A_LATCH_INVERT)) ? spread(wdata, 1'b0) :
                    (wr_en && hit(addr, GPQ_PORT_B_LATCH_INVERT)) ? spread(wdata, 1'b1) : '0;
  // All selected bits move in one cycle; software sets latch before direction
  assign latch_next = (((latch_reg & ~wr_mask) | (wr_val & wr_mask)) | raise_m) & ~lower_m
                      ^ invert_m;

  always_ff @(posedge clock) begin
    if (!reset_n)
      latch_reg <= GPQ_LATCH_RESET;
    else
      latch_reg <= latch_next;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dir_reg      <= GPQ_DIR_RESET;
      func_reg     <= GPQ_FUNC_RESET;
      qual_reg     <= GPQ_QUAL_RESET;
      pull_off_reg <= GPQ_PULLUP_OFF_RESET;
      ctl_a_reg    <= 32'h0000_0000;
      ctl_b_reg    <= 32'h0000_0000;
      wake_reg     <= 32'h0000_0000;
      src_one_reg  <= GPQ_SRC_RESET;
      src_two_reg  <= GPQ_SRC_RESET;
      src_nmi_reg  <= GPQ_SRC_RESET;
    end else if (wr_en) begin
      case (addr)
        GPQ_PORT_A_DIRECTION:     dir_reg[31:0]      <= wdata;
        GPQ_PORT_B_DIRECTION:     dir_reg[34:32]     <= wdata[2:0];
        GPQ_PORT_A_PULLUP_OFF:    pull_off_reg[31:0] <= wdata;
        GPQ_PORT_B_PULLUP_OFF:    pull_off_reg[34:32] <= wdata[2:0];
        GPQ_PORT_A_LOW_QUAL:      qual_reg[31:0]     <= wdata;
        GPQ_PORT_A_HIGH_QUAL:     qual_reg[63:32]    <= wdata;
        GPQ_PORT_B_QUAL:          qual_reg[69:64]    <= wdata[5:0];
        GPQ_PORT_A_LOW_FUNC:      func_reg[31:0]     <= wdata;
        GPQ_PORT_A_HIGH_FUNC:     func_reg[63:32]    <= wdata;
        GPQ_PORT_B_FUNC:          func_reg[69:64]    <= wdata[5:0];
        GPQ_PORT_A_SAMPLE_PERIOD: ctl_a_reg          <= wdata;
        GPQ_PORT_B_SAMPLE_PERIOD: ctl_b_reg          <= {24'h000000, wdata[7:0]};
        GPQ_WAKE_SOURCE_SELECT:   wake_reg           <= wdata;
        GPQ_EXT_IRQ_ONE_SOURCE:   src_one_reg        <= wdata[4:0];
        GPQ_EXT_IRQ_TWO_SOURCE:   src_two_reg        <= wdata[4:0];
        GPQ_EXT_NMI_SOURCE:       src_nmi_reg        <= wdata[4:0];
        default: ;
      endcase
    end
  end

  // Read mux; raise/lower/invert and unmapped addresses read zero
  always_comb begin
    case (addr)
      GPQ_PORT_A_PIN_LEVEL:     rd_mux = level[31:0];
      GPQ_PORT_B_PIN_LEVEL:     rd_mux = {29'h0, level[34:32]};
      GPQ_PORT_A_DIRECTION:     rd_mux = dir_reg[31:0];
      GPQ_PORT_B_DIRECTION:     rd_mux = {29'h0, dir_reg[34:32]};
      GPQ_PORT_A_PULLUP_OFF:    rd_mux = pull_off_reg[31:0];
      GPQ_PORT_B_PULLUP_OFF:    rd_mux = {29'h0, pull_off_reg[34:32]};
      GPQ_PORT_A_LOW_QUAL:      rd_mux = qual_reg[31:0];
      GPQ_PORT_A_HIGH_QUAL:     rd_mux = qual_reg[63:32];
      GPQ_PORT_B_QUAL:          rd_mux = {26'h0, qual_reg[69:64]};
      GPQ_PORT_A_LOW_FUNC:      rd_mux = func_reg[31:0];
      GPQ_PORT_A_HIGH_FUNC:     rd_mux = func_reg[63:32];
      GPQ_PORT_B_FUNC:          rd_mux = {26'h0, func_reg[69:64]};
      GPQ_PORT_A_SAMPLE_PERIOD: rd_mux = ctl_a_reg;
      GPQ_PORT_B_SAMPLE_PERIOD: rd_mux = ctl_b_reg;
      GPQ_WAKE_SOURCE_SELECT:   rd_mux = wake_reg;
      GPQ_EXT_IRQ_ONE_SOURCE:   rd_mux = {27'h0, src_one_reg};
      GPQ_EXT_IRQ_TWO_SOURCE:   rd_mux = {27'h0, src_two_reg};
      GPQ_EXT_NMI_SOURCE:       rd_mux = {27'h0, src_nmi_reg};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      rdata_reg <= 32'h0000_0000;
    else if (rd_en)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= 32'h0000_0000;
  end

  assign rdata = rdata_reg;
endmodule

// *** gpq_port_bench.sv ***
// Self-checking bench for the pin port
`timescale 1ns/100ps
module gpq_port_bench
  import gpq_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic [34:0] pin_in, pin_out, pin_oe, pullup_en, periph_in;
  logic [34:0] periph_out = 35'h0, periph_oe = 35'h0, ext_val = 35'h0, ext_oe = 35'h0;
  logic [69:0] function_sel;
  logic [31:0] wake_source_select;
  logic        irq1, irq2, nmi;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #2.5 clock = ~clock;
  gpq_port dut_u (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .periph_in(periph_in), .periph_out(periph_out), .periph_oe(periph_oe), .function_sel(function_sel),
    .wake_source_select(wake_source_select), .ext_irq_one(irq1), .ext_irq_two(irq2), .ext_nonmaskable_irq(nmi));
  gpq_pads pads_u (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic tally(input string nm, input logic [34:0] e, input logic [34:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    tally(nm, {3'h0, e & m}, {3'h0, rdata & m});
  endtask
  task automatic chk_pin(input string nm, input logic [34:0] e, input logic [34:0] g);
    tally(nm, e, g);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole run needs about 125 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    wait_cyc(1);
    chk_pin("pullup_en", 35'h7_FFFF_F000, pullup_en);
    chk_pin("pin_oe", 35'h0, pin_oe);
    chk_pin("pin_out", 35'h0, pin_out);
    chk_pin("function_sel", 35'h0, function_sel[34:0] | function_sel[69:35]);
    rd_chk("qual reset", GPQ_PORT_A_LOW_QUAL, 32'h0, 32'hFFFF_FFFF);
    // Pins 0-11 float after reset, so they are masked
    for (int i = 0; i < 8; i++) begin
      rd_chk("data block", 16'h6FC0 + 16'(2 * i), i == 0 ? 32'hFFFF_F000 : i == 4 ? 32'h7 : 32'h0, i == 0 ? 32'hFFFF_F000 : 32'hFFFF_FFFF);
    end
    rd_chk("unmapped", 16'h6FD0, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    wr(GPQ_PORT_A_LATCH_RAISE, 32'hA5A5_0F0F);
    wr(GPQ_PORT_A_LATCH_LOWER, 32'h0000_0F00);
    wr(GPQ_PORT_A_LATCH_INVERT, 32'hFF00_0001);
    chk_pin("pin_oe input", 35'h0, pin_oe);
    wr(GPQ_PORT_A_DIRECTION, 32'hFFFF_FFFF);
    chk_pin("pin_out kept", {3'h0, 32'h5AA5_000E}, pin_out);
    wait_cyc(4);
    rd_chk("loopback", GPQ_PORT_A_PIN_LEVEL, 32'h5AA5_000E, 32'hFFFF_FFFF);
    wr(GPQ_PORT_A_PIN_LEVEL, 32'h1234_5678);
    wr(GPQ_PORT_B_PIN_LEVEL, 32'hFFFF_FFFF);
    wr(GPQ_PORT_B_DIRECTION, 32'hFFFF_FFFF);
    wr(GPQ_PORT_B_LATCH_INVERT, 32'h0000_0002);
    chk_pin("pin_out data", {3'h5, 32'h1234_5678}, pin_out);
    wait_cyc(4);
    rd_chk("port b", GPQ_PORT_B_PIN_LEVEL, 32'h5, 32'hFFFF_FFFF);
    $display("test latches done");
    wr(GPQ_PORT_A_PULLUP_OFF, 32'h0000_F000);
    chk_pin("pullups on", 35'h7_FFFF_0FFF, pullup_en);
    wr(GPQ_PORT_A_DIRECTION, 32'h0);
    wr(GPQ_PORT_B_DIRECTION, 32'h0);
    chk_pin("pin_oe off", 35'h0, pin_oe);
    ext_oe  <= 35'h7_FFFF_FFFF;
    ext_val <= 35'h20;
    wr(GPQ_EXT_IRQ_ONE_SOURCE, 32'h5);
    wr(GPQ_EXT_IRQ_TWO_SOURCE, 32'h4);
    wr(GPQ_EXT_NMI_SOURCE, 32'h5);
    wr(GPQ_WAKE_SOURCE_SELECT, 32'h0000_00F0);
    wait_cyc(4);
    chk_pin("irq levels", 35'h5, {32'h0, irq1, irq2, nmi});
    chk_pin("wake", 35'hF0, {3'h0, wake_source_select});
    $display("test sources done");
    // Pin 0 six samples, pin 2 async while GPIO
    wr(GPQ_PORT_A_LOW_QUAL, 32'h0000_0032);
    @(posedge clock);
    ext_val[0] <= 1'b1;
    repeat (3) @(posedge clock);
    ext_val[0] <= 1'b0;
    wait_cyc(10);
    rd_chk("glitch ignored", GPQ_PORT_A_PIN_LEVEL, 32'h0, 32'h1);
    ext_val[0] <= 1'b1;
    ext_val[2] <= 1'b1;
    // An async path would already show the new level here
    #1;
    chk_pin("gpio no async", 35'h0, {34'h0, periph_in[2]});
    wait_cyc(12);
    rd_chk("window pass", GPQ_PORT_A_PIN_LEVEL, 32'h5, 32'h5);
    // Period 1 halves the sample rate, so 8 low cycles give only 4 samples
    wr(GPQ_PORT_A_SAMPLE_PERIOD, 32'h0000_0001);
    ext_val[0] <= 1'b0;
    wait_cyc(8);
    rd_chk("slow period", GPQ_PORT_A_PIN_LEVEL, 32'h1, 32'h1);
    ext_val[0] <= 1'b1;
    $display("test qualify done");
    @(posedge clock);
    periph_oe[1]  <= 1'b1;
    periph_out[1] <= 1'b1;
    wr(GPQ_PORT_A_LOW_FUNC, 32'h0000_003C);
    chk_pin("periph drive", 35'h3, {33'h0, pin_oe[1], pin_out[1]});
    // Pin 2 now feeds a peripheral, so its async choice takes effect at once
    ext_val[2] <= 1'b0;
    #1;
    chk_pin("async bypass", 35'h0, {34'h0, periph_in[2]});
    wait_cyc(4);
    chk_pin("periph in", 35'h1, {34'h0, periph_in[1]});
    rd_chk("periph level", GPQ_PORT_A_PIN_LEVEL, 32'h2, 32'h2);
    $display("test peripheral done");
    wrap_up;
  end
endmodule

// *** gpq_port_monitor.sv ***
// Port-level checker for the pin port
`timescale 1ns/100ps
module gpq_port_monitor
  import gpq_pkg::*;
#(
  parameter int NUM_PINS = GPQ_NUM_PINS
)
(
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic [GPQ_ADDR_W-1:0] addr,
  input wire logic [31:0]           wdata,
  input wire logic                  wr_en,
  input wire logic                  rd_en,
  input wire logic [31:0]           rdata,
  input wire logic [NUM_PINS-1:0]   pin_out,
  input wire logic [NUM_PINS-1:0]   pin_oe,
  input wire logic [NUM_PINS-1:0]   pullup_en,
  input wire logic [NUM_PINS-1:0]   periph_out,
  input wire logic [NUM_PINS-1:0]   periph_oe,
  input wire logic [69:0]           function_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Latch checks only run while every pin is GPIO
  sequence gpio_wr_s(a);
    wr_en && addr == a && function_sel == '0;
  endsequence
  reset_state_a: assert property ($rose(reset_n) |-> pullup_en == ~GPQ_PULLUP_OFF_RESET && pin_oe == '0 && pin_out == '0)
    else $error("reset state wrong");
  idle_rdata_a: assert property (!$past(rd_en) |-> rdata == '0)
    else $error("read data outside read cycle");
  strobe_zero_a: assert property (rd_en && addr inside {16'h6FC2, 16'h6FC4, 16'h6FC6, 16'h6FCA, 16'h6FCC, 16'h6FCE} |=> rdata == '0)
    else $error("strobe register read not zero");
  port_b_upper_a: assert property (rd_en && addr == GPQ_PORT_B_PIN_LEVEL |=> rdata[31:3] == '0)
    else $error("port b upper bits not zero");
  raise_latch_a: assert property (gpio_wr_s(GPQ_PORT_A_LATCH_RAISE) |=> (pin_out[31:0] & $past(wdata)) == $past(wdata))
    else $error("raise did not set latches");
  lower_latch_a: assert property (gpio_wr_s(GPQ_PORT_A_LATCH_LOWER) |=> (pin_out[31:0] & $past(wdata)) == '0)
    else $error("lower did not clear latches");
  invert_latch_a: assert property (gpio_wr_s(GPQ_PORT_A_LATCH_INVERT) |=> pin_out == ($past(pin_out) ^ {3'h0, $past(wdata)}))
    else $error("invert wrong");
  data_load_a: assert property (gpio_wr_s(GPQ_PORT_A_PIN_LEVEL) |=> pin_out[31:0] == $past(wdata))
    else $error("data write did not load latches");
  dir_drive_a: assert property (gpio_wr_s(GPQ_PORT_A_DIRECTION) |=> pin_oe[31:0] == $past(wdata))
    else $error("direction not applied");
  periph_pass_a: assert property (function_sel[3:2] != GPQ_FUNC_GPIO |-> pin_oe[1] == periph_oe[1] && pin_out[1] == periph_out[1])
    else $error("peripheral drive not passed");
endmodule
bind gpq_port gpq_port_monitor #(.NUM_PINS(NUM_PINS)) mon_u (.clock(clock), .reset_n(reset_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .pullup_en(pullup_en), .periph_out(periph_out), .periph_oe(periph_oe), .function_sel(function_sel));

// *** gpq_qualifier.sv ***
// One pin input qualifier: synchroniser, sample filter and async bypass
`timescale 1ns/100ps
module gpq_qualifier
  import gpq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       pin_in,
  input  wire logic       sample_tick,
  input  wire logic [1:0] qual_sel,
  input  wire logic       is_gpio,
  output logic            level
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic [5:0] hist_reg;
  logic       filt_reg;
  logic       six_mode;
  logic       all_hi;
  logic       all_lo;
  logic       use_async;

  assign six_mode  = (qual_sel == GPQ_QUAL_SIX);
  assign all_hi    = six_mode ? (&hist_reg) : (&hist_reg[2:0]);
  assign all_lo    = six_mode ? ~(|hist_reg) : ~(|hist_reg[2:0]);
  // GPIO input ignores the async choice and falls back to sync only
  assign use_async = (qual_sel == GPQ_QUAL_ASYNC) && !is_gpio;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hist_reg <= 6'h00;
      filt_reg <= 1'b0;
    end else if (sample_tick) begin
      hist_reg <= {hist_reg[4:0], sync2_reg};
      if (all_hi)
        filt_reg <= 1'b1;
      else if (all_lo)
        filt_reg <= 1'b0;
    end
  end

  // Async path is combinational so it still works without the clock
  always_comb begin
    if (use_async)
      level = pin_in;
    else if (qual_sel == GPQ_QUAL_THREE || six_mode)
      level = filt_reg;
    else
      level = sync2_reg;
  end
endmodule
